// ===== src/scrs_sequencer.v
// System clock divider, clock gating and reset sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "scrs_defs.vh"

module scrs_sequencer (
  input wire clk,
  input wire srst,
  input wire power_on_pulse,
  input wire low_voltage_monitor,
  input wire watchdog_timeout,
  input wire illegal_opcode,
  input wire illegal_address_fetch,
  input wire reset_pin_in,
  input wire reset_pin_enable,
  input wire irq_pin_enable,
  input wire short_stop_recovery,
  input wire monitor_mode,
  input wire stop_request,
  input wire wait_request,
  input wire wakeup_event,
  input wire cause_read_clear,
  output reg osc_clock_x2,
  output reg bus_clock,
  output reg cpu_clock_en,
  output reg periph_clock_en,
  output reg internal_reset,
  output reg reset_pin_out,
  output reg reset_pin_oe,
  output reg port_a_line3_gpio,
  output reg port_a_line2_gpio,
  output reg [15:0] reset_vector,
  output reg [7:0] reset_cause_register
);

  // --------------------------------------------------------------------------
  // State encoding.
  // --------------------------------------------------------------------------
  localparam [3:0] ST_RUN = 4'h0;
  localparam [3:0] ST_STAB = 4'h1;
  localparam [3:0] ST_PIN = 4'h2;
  localparam [3:0] ST_HOLD = 4'h3;
  localparam [3:0] ST_TAIL = 4'h4;
  localparam [3:0] ST_EXT = 4'h5;
  localparam [3:0] ST_STOP = 4'h6;
  localparam [3:0] ST_SREC = 4'h7;
  localparam [3:0] ST_WAIT = 4'h8;
  localparam integer MIN_LOW_FULL = `SCRS_MIN_RESET_LOW_CYC;
  localparam [7:0] MIN_LOW = MIN_LOW_FULL[7:0];

  reg [3:0] state;
  reg [5:0] phase_count;
  reg [7:0] low_count;
  reg drive_pin;
  reg [12:0] stab_count;
  reg cnt_clear;
  reg cnt_run;
  reg [1:0] div;
  reg wdog_meta;
  reg wdog_sync;
  reg wdog_seen;
  reg [12:0] stop_target;

  // Internal reset is asserted in the reset sequencing states STAB, PIN, HOLD, TAIL and EXT, not in STOP, SREC or WAIT.
  function in_reset;
    input [3:0] s;
    begin
      in_reset = (s == ST_STAB) || (s == ST_PIN) || (s == ST_HOLD) || (s == ST_TAIL) || (s == ST_EXT);
    end
  endfunction

  wire long_src;
  wire short_src;
  wire ext_low;

  assign long_src = power_on_pulse | low_voltage_monitor;
  // Only the rising edge of the synchronised watchdog counts, so a long request starts one sequence.
  assign short_src = (wdog_sync & ~wdog_seen) | illegal_opcode | illegal_address_fetch;
  // While the sequencer drives the pin itself, the low level it reads back is its own.
  assign ext_low = reset_pin_enable & ~reset_pin_in & ~reset_pin_oe;

  // --------------------------------------------------------------------------
  // Watchdog request synchroniser.
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      wdog_meta <= 1'b0;
      wdog_sync <= 1'b0;
      wdog_seen <= 1'b0;
    end
    else
    begin
      wdog_meta <= watchdog_timeout;
      wdog_sync <= wdog_meta;
      wdog_seen <= wdog_sync;
    end
  end

  // --------------------------------------------------------------------------
  // Stabilisation counter.
  // --------------------------------------------------------------------------
  // It runs on the opposite edge so that its value is settled when the
  // sequencer compares it on the next rising edge.
  always @(negedge clk)
  begin
    if (srst || cnt_clear)
    begin
      stab_count <= 13'h0000;
    end
    else if (cnt_run)
    begin
      stab_count <= stab_count + 13'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Reset and power state sequencer.
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_STAB;
      phase_count <= 6'h00;
      low_count <= 8'h00;
      drive_pin <= 1'b1;
      cnt_clear <= 1'b1;
      cnt_run <= 1'b0;
      stop_target <= `SCRS_STAB_LONG;
      reset_cause_register <= `SCRS_CAUSE_RESET;
    end
    else
    begin
      cnt_clear <= 1'b0;
      cnt_run <= (state != ST_STOP);
      // Set wins over a read-clear in the same cycle.
      if (cause_read_clear && !in_reset(state))
      begin
        reset_cause_register <= 8'h00;
      end
      if (long_src)
      begin
        // Power-on and low voltage restart the long count and keep the
        // counter cleared as long as the level stands.
        state <= ST_STAB;
        cnt_clear <= 1'b1;
        drive_pin <= 1'b1;
        phase_count <= 6'h00;
        if (power_on_pulse)
        begin
          reset_cause_register <= `SCRS_CAUSE_RESET;
        end
        else
        begin
          reset_cause_register[`SCRS_CAUSE_LOW_VOLT] <= 1'b1;
        end
      end
      else if (short_src && state != ST_STAB)
      begin
        state <= ST_PIN;
        cnt_clear <= 1'b1;
        drive_pin <= 1'b1;
        phase_count <= 6'h00;
        if (wdog_sync && !wdog_seen)
        begin
          reset_cause_register[`SCRS_CAUSE_WDOG] <= 1'b1;
        end
        if (illegal_opcode)
        begin
          reset_cause_register[`SCRS_CAUSE_ILOP] <= 1'b1;
        end
        if (illegal_address_fetch)
        begin
          reset_cause_register[`SCRS_CAUSE_ILAD] <= 1'b1;
        end
      end
      else if (ext_low && state != ST_EXT && state != ST_STAB)
      begin
        // The counter is left alone for a pin reset.
        state <= ST_EXT;
        low_count <= 8'h01;
        drive_pin <= 1'b0;
        phase_count <= 6'h00;
      end
      else
      begin
        case (state)
          ST_RUN:
          begin
            if (stop_request)
            begin
              state <= ST_STOP;
              cnt_clear <= 1'b1;
            end
            else if (wait_request)
            begin
              state <= ST_WAIT;
            end
          end
          ST_STAB:
          begin
            if (stab_count == `SCRS_STAB_LONG)
            begin
              state <= ST_PIN;
              phase_count <= 6'h00;
            end
          end
          ST_PIN:
          begin
            phase_count <= phase_count + 6'h01;
            if (phase_count == `SCRS_PIN_LOW_CYC - 6'h01)
            begin
              state <= ST_HOLD;
              phase_count <= 6'h00;
            end
          end
          ST_HOLD:
          begin
            phase_count <= phase_count + 6'h01;
            if (phase_count == `SCRS_HOLD_CYC - 6'h01)
            begin
              state <= ST_TAIL;
              phase_count <= 6'h00;
            end
          end
          ST_TAIL:
          begin
            phase_count <= phase_count + 6'h01;
            if (phase_count == `SCRS_TAIL_CYC - 6'h01)
            begin
              state <= ST_RUN;
              phase_count <= 6'h00;
            end
          end
          ST_EXT:
          begin
            if (low_count != 8'hff)
            begin
              low_count <= low_count + 8'h01;
            end
            if (low_count >= MIN_LOW)
            begin
              reset_cause_register[`SCRS_CAUSE_PIN] <= 1'b1;
            end
            if (!ext_low)
            begin
              // Released: run the same release tail as an internal
              // source, without driving the pin.
              state <= ST_PIN;
              phase_count <= 6'h00;
            end
          end
          ST_STOP:
          begin
            if (wakeup_event)
            begin
              state <= ST_SREC;
              stop_target <= short_stop_recovery ? `SCRS_STAB_SHORT : `SCRS_STAB_LONG;
            end
          end
          ST_SREC:
          begin
            if (stab_count >= stop_target)
            begin
              state <= ST_RUN;
            end
          end
          ST_WAIT:
          begin
            if (wakeup_event)
            begin
              state <= ST_RUN;
            end
          end
          default:
          begin
            state <= ST_RUN;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock divider and gating.
  // --------------------------------------------------------------------------
  // The divider is parked low while the oscillator is stabilising, so the
  // bus clocks restart from a clean phase.
  always @(posedge clk)
  begin
    if (srst)
    begin
      div <= 2'b00;
      osc_clock_x2 <= 1'b0;
      bus_clock <= 1'b0;
      cpu_clock_en <= 1'b0;
      periph_clock_en <= 1'b0;
    end
    else
    begin
      if (state == ST_STAB || state == ST_STOP || state == ST_SREC)
      begin
        div <= 2'b00;
      end
      else
      begin
        div <= div + 2'b01;
      end
      osc_clock_x2 <= div[0];
      bus_clock <= div[1];
      cpu_clock_en <= (state == ST_RUN);
      periph_clock_en <= (state == ST_RUN) || (state == ST_WAIT);
    end
  end

  // --------------------------------------------------------------------------
  // Reset outputs and pin control.
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      internal_reset <= 1'b1;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
      port_a_line3_gpio <= 1'b1;
      port_a_line2_gpio <= 1'b1;
      reset_vector <= `SCRS_VECTOR_USER;
    end
    else
    begin
      internal_reset <= in_reset(state);
      reset_pin_out <= 1'b0;
      reset_pin_oe <= reset_pin_enable && drive_pin && (state == ST_PIN);
      port_a_line3_gpio <= ~reset_pin_enable;
      port_a_line2_gpio <= ~irq_pin_enable;
      reset_vector <= monitor_mode ? `SCRS_VECTOR_MONITOR : `SCRS_VECTOR_USER;
    end
  end

endmodule // scrs_sequencer
`default_nettype wire

// ===== src/scrs_defs.vh
// Constants for the system clock and reset sequencer.
`ifndef SCRS_DEFS_VH
`define SCRS_DEFS_VH

// ----------------------------------------------------------------------------
// Clock rate and timing.
// ----------------------------------------------------------------------------
`define SCRS_CLK_PERIOD_PS 4000
`define SCRS_MIN_RESET_LOW_NS 100
`define SCRS_MIN_RESET_LOW_CYC ((`SCRS_MIN_RESET_LOW_NS * 1000 + `SCRS_CLK_PERIOD_PS - 1) / `SCRS_CLK_PERIOD_PS)

// Cycle counts of the reset and stop recovery sequences.
`define SCRS_STAB_LONG 13'h1000
`define SCRS_STAB_SHORT 13'h0020
`define SCRS_PIN_LOW_CYC 6'h20
`define SCRS_HOLD_CYC 6'h20
`define SCRS_TAIL_CYC 6'h03

// ----------------------------------------------------------------------------
// Reset cause register fields.
// ----------------------------------------------------------------------------
`define SCRS_CAUSE_POR 7
`define SCRS_CAUSE_PIN 6
`define SCRS_CAUSE_WDOG 5
`define SCRS_CAUSE_ILOP 4
`define SCRS_CAUSE_ILAD 3
`define SCRS_CAUSE_LOW_VOLT 1
`define SCRS_CAUSE_RESET 8'h80

// ----------------------------------------------------------------------------
// Reset vectors.
// ----------------------------------------------------------------------------
`define SCRS_VECTOR_USER 16'hfffe
`define SCRS_VECTOR_MONITOR 16'hfefe

`endif

// ===== test/scrs_seq_asserts.sv
// Port checker for the clock and reset sequencer.
`timescale 1ns/100ps
`default_nettype none
module scrs_seq_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic illegal_opcode,
  input wire logic illegal_address_fetch,
  input wire logic reset_pin_enable,
  input wire logic irq_pin_enable,
  input wire logic stop_request,
  input wire logic wait_request,
  input wire logic osc_clock_x2,
  input wire logic bus_clock,
  input wire logic cpu_clock_en,
  input wire logic periph_clock_en,
  input wire logic internal_reset,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic port_a_line3_gpio,
  input wire logic port_a_line2_gpio,
  input wire logic [7:0] reset_cause_register
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [5:0] oe_cnt;
  always_ff @(posedge clk)
    oe_cnt <= (srst || !reset_pin_oe) ? 6'h00 : oe_cnt + 6'h01;
  chk_pin_len: assert property ($fell(reset_pin_oe) |-> oe_cnt == 6'h20)
    else $error("Pin drive length wrong.");
  chk_pin_drive: assert property (reset_pin_oe |-> !reset_pin_out && reset_pin_enable && internal_reset)
    else $error("Pin driven without cause.");
  chk_hold_after: assert property ($fell(reset_pin_oe) |-> internal_reset ##34 internal_reset ##1 !internal_reset)
    else $error("Reset tail after pin release wrong.");
  chk_short_total: assert property ((illegal_opcode || illegal_address_fetch) && !internal_reset
    |-> ##2 internal_reset ##66 internal_reset ##1 !internal_reset)
    else $error("Short reset length wrong.");
  chk_cause_ilop: assert property (illegal_opcode && !internal_reset |-> ##[1:2] reset_cause_register[4])
    else $error("Opcode cause flag missing.");
  chk_cpu_held: assert property (internal_reset |-> !cpu_clock_en)
    else $error("CPU clock runs in reset.");
  chk_half_rate: assert property (periph_clock_en && $past(periph_clock_en) |-> osc_clock_x2 != $past(osc_clock_x2))
    else $error("Half rate clock stalled.");
  chk_wait_clocks: assert property (wait_request && !stop_request && cpu_clock_en
    |-> ##2 !cpu_clock_en && periph_clock_en)
    else $error("Wait clocks wrong.");
  chk_stop_clocks: assert property (stop_request && cpu_clock_en
    |-> ##2 !cpu_clock_en && !periph_clock_en ##1 !bus_clock)
    else $error("Stop clocks wrong.");
  chk_gpio_mode: assert property (!$past(srst) |-> port_a_line3_gpio == !$past(reset_pin_enable)
    && port_a_line2_gpio == !$past(irq_pin_enable))
    else $error("Port line mode wrong.");
endmodule // scrs_seq_asserts
bind scrs_sequencer scrs_seq_asserts u_chk (.clk(clk), .srst(srst), .illegal_opcode(illegal_opcode),
  .illegal_address_fetch(illegal_address_fetch), .reset_pin_enable(reset_pin_enable),
  .irq_pin_enable(irq_pin_enable), .stop_request(stop_request), .wait_request(wait_request),
  .osc_clock_x2(osc_clock_x2), .bus_clock(bus_clock), .cpu_clock_en(cpu_clock_en),
  .periph_clock_en(periph_clock_en), .internal_reset(internal_reset), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .port_a_line3_gpio(port_a_line3_gpio), .port_a_line2_gpio(port_a_line2_gpio),
  .reset_cause_register(reset_cause_register));
`default_nettype wire

// ===== test/scrs_far_end.sv
// Model of the chips that share the reset pin, with the pin pull-up.
`timescale 1ns/100ps
`default_nettype none
module scrs_far_end (
  input wire logic clk,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic ext_pull,
  input wire logic clr,
  output logic pin_level,
  output logic [7:0] low_seen
);
  // Wired low from either party; the pull-up wins when nobody drives.
  assign pin_level = !((reset_pin_oe && !reset_pin_out) || ext_pull);
  always @(posedge clk)
    low_seen <= clr ? 8'h00 : low_seen + {7'h00, reset_pin_oe && !pin_level};
endmodule // scrs_far_end
`default_nettype wire

// ===== test/system_clock_reset_sequencer_tb_top.sv
// Self-checking bench for the clock and reset sequencer.
`timescale 1ns/100ps
`default_nettype none
module system_clock_reset_sequencer_tb_top;
  logic clk, por, srst, lvm, wdog, ilop, ilad, pin_en, irq_en, ssr, mon, stp, wt, wake, clr, ext, mclr;
  logic x2, bclk, cpu_en, per_en, ir, rpo, roe, g3, g2, pin;
  logic [15:0] vec;
  logic [7:0] cause, low_seen;
  int n_mismatch = 0;
  int total_checks = 0;
  scrs_sequencer DUT (.clk(clk), .srst(srst), .power_on_pulse(por), .low_voltage_monitor(lvm),
    .watchdog_timeout(wdog), .illegal_opcode(ilop), .illegal_address_fetch(ilad), .reset_pin_in(pin),
    .reset_pin_enable(pin_en), .irq_pin_enable(irq_en), .short_stop_recovery(ssr), .monitor_mode(mon),
    .stop_request(stp), .wait_request(wt), .wakeup_event(wake), .cause_read_clear(clr), .osc_clock_x2(x2),
    .bus_clock(bclk), .cpu_clock_en(cpu_en), .periph_clock_en(per_en), .internal_reset(ir),
    .reset_pin_out(rpo), .reset_pin_oe(roe), .port_a_line3_gpio(g3), .port_a_line2_gpio(g2),
    .reset_vector(vec), .reset_cause_register(cause));
  scrs_far_end u_far (.clk(clk), .reset_pin_oe(roe), .reset_pin_out(rpo), .ext_pull(ext), .clr(mclr),
    .pin_level(pin), .low_seen(low_seen));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Counts edges until the chosen output reads v; a bounded wait so a hang shows as a count.
  task automatic until_v(input bit w, input logic v, input int lim, output int n);
    n = 0;
    while (((w ? cpu_en : ir) !== v) && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic [15:0] in_rng(input int n, input int lo, input int hi);
    return {15'h0000, n >= lo && n <= hi};
  endfunction
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_on;
    int n;
    chk({15'h0000, cpu_en}, 16'h0000);
    chk({8'h00, cause}, 16'h0080);
    until_v(0, 1'b0, 5000, n);
    chk(in_rng(n, 4160, 4170), 16'h0001);
    chk(vec, 16'hfffe);
  endtask
  task automatic t_bus_div;
    int nb, nx;
    logic pb, px;
    nb = 0;
    nx = 0;
    repeat (12) @(posedge clk);
    pb = bclk;
    px = x2;
    repeat (40)
    begin
      @(posedge clk);
      nb += int'(bclk && !pb);
      nx += int'(x2 && !px);
      pb = bclk;
      px = x2;
    end
    chk(nb[15:0], 16'h000a);
    chk(nx[15:0], 16'h0014);
  endtask
  // Sources 0..2: illegal opcode, illegal address, watchdog; the watchdog is given a two-cycle pulse.
  task automatic t_short(input int s, input logic [7:0] bitv);
    int n;
    repeat (12) @(posedge clk);
    pin_en <= 1'b1;
    clr <= 1'b1;
    mclr <= 1'b1;
    @(posedge clk);
    {clr, mclr} <= 2'b00;
    {ilop, ilad, wdog} <= {s == 0, s == 1, s == 2};
    repeat (s == 2 ? 2 : 1) @(posedge clk);
    {ilop, ilad, wdog} <= 3'b000;
    until_v(0, 1'b1, 8, n);
    until_v(0, 1'b0, 200, n);
    chk(n[15:0], 16'h0043);
    chk({8'h00, cause}, {8'h00, bitv});
    chk({8'h00, low_seen}, 16'h0020);
    chk(vec, mon ? 16'hfefe : 16'hfffe);
  endtask
  // Long sources: p selects a power-on pulse, otherwise a low-voltage level.
  task automatic t_long(input logic p);
    int n;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    {por, lvm} <= {p, !p};
    repeat (3) @(posedge clk);
    {por, lvm} <= 2'b00;
    until_v(0, 1'b0, 5000, n);
    chk(in_rng(n, 4160, 4170), 16'h0001);
    chk({8'h00, cause}, p ? 16'h0080 : 16'h0002);
  endtask
  task automatic t_pin(input logic en, input int len, input logic [7:0] exp);
    repeat (12) @(posedge clk);
    pin_en <= en;
    irq_en <= !en;
    clr <= 1'b1;
    mclr <= 1'b1;
    @(posedge clk);
    {clr, mclr} <= 2'b00;
    ext <= 1'b1;
    repeat (len) @(posedge clk);
    ext <= 1'b0;
    chk({15'h0000, ir}, {15'h0000, en});
    repeat (80) @(posedge clk);
    chk({8'h00, cause}, {8'h00, exp});
    chk({8'h00, low_seen}, 16'h0000);
    chk({14'h0000, g3, g2}, {14'h0000, !en, en});
  endtask
  task automatic t_stop(input logic s, input int lo, input int hi);
    int n;
    repeat (12) @(posedge clk);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    ssr <= s;
    repeat (6) @(posedge clk);
    chk({14'h0000, cpu_en, per_en}, 16'h0000);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    until_v(1, 1'b1, 5000, n);
    chk(in_rng(n, lo, hi), 16'h0001);
  endtask
  task automatic t_wait;
    repeat (12) @(posedge clk);
    wt <= 1'b1;
    @(posedge clk);
    wt <= 1'b0;
    repeat (6) @(posedge clk);
    chk({14'h0000, cpu_en, per_en}, 16'h0001);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (6) @(posedge clk);
    chk({15'h0000, cpu_en}, 16'h0001);
  endtask
  initial
  begin
    {por, srst, lvm, wdog, ilop, ilad, pin_en, irq_en, ssr, mon, stp, wt, wake, clr, ext, mclr} = 16'h4001;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_power_on();
    t_bus_div();
    t_short(0, 8'h10);
    t_short(1, 8'h08);
    mon <= 1'b1;
    t_short(2, 8'h20);
    mon <= 1'b0;
    t_long(1'b1);
    t_long(1'b0);
    // Pulls of 30 cycles pass the minimum low time; 10 cycles reset without the flag.
    t_pin(1'b1, 30, 8'h40);
    t_pin(1'b1, 10, 8'h00);
    t_pin(1'b0, 30, 8'h00);
    t_wait();
    t_stop(1'b1, 32, 40);
    t_stop(1'b0, 4096, 4104);
    complete_run();
  end
  initial
  begin
    #(4 * 40000);
    n_mismatch++;
    complete_run();
  end
endmodule // system_clock_reset_sequencer_tb_top
`default_nettype wire
